// ===== design/spd_converter.sv
// Digital side of an 8-bit pipelined sampling converter with power-down
//
// Function
// - In-span input becomes an 8-bit straight binary code.
// - Input below bottom reference gives all-zero code.
// - Input above top reference gives all-ones code.
// - Sample on falling edge; code appears 2.5 cycles later.
// - Converts one sample per cycle while the request is low and the output buffer has room.
// - Low request input low means normal operation.
// - Request high powers down and holds the last converted code.
// - Codes invalid about 1 us after request falls; capturer discards them.
// - Stopped clock keeps the last code on the outputs.
// - One new word per cycle, changing after the rising edge.
`timescale 1ns/1ps
module spd_converter
  import spd_pkg::*;
#(
  parameter int IN_W = IN_W_DEF
) (
  input  wire logic            clk,
  input  wire logic            reset_n,
  input  wire logic [IN_W-1:0] sample_in,
  input  wire logic [IN_W-1:0] ref_bottom_level,
  input  wire logic [IN_W-1:0] ref_top_level,
  input  wire logic            low_power_request,
  output      logic [7:0]      code_out,
  output      logic            code_valid,
  output      logic            code_settled,
  input  wire logic            code_ready,
  output      logic            powered_down
);

  // ****************************************
  // Quantiser
  // ****************************************
  localparam int NUM_W = IN_W + CODE_W;

  function automatic logic [7:0] quantise(
    input logic [IN_W-1:0] v,
    input logic [IN_W-1:0] bot,
    input logic [IN_W-1:0] top
  );
    logic [NUM_W-1:0] num;
    logic [NUM_W-1:0] span;
    logic [NUM_W-1:0] q;
    num  = '0;
    span = '0;
    q    = '0;
    if (v <= bot) begin
      quantise = CODE_ZERO;
    end else if (v >= top) begin
      quantise = CODE_ONES;
    end else begin
      num      = NUM_W'(v - bot) * NUM_W'(CODE_ONES);
      span     = NUM_W'(top - bot);
      q        = num / span;
      quantise = q[7:0];
    end
  endfunction

  // ****************************************
  // Falling-edge capture
  // ****************************************
  logic [IN_W-1:0] smp_ff;
  logic [IN_W-1:0] nxt_smp;

  always_comb begin
    nxt_smp = sample_in;
  end

  always_ff @(negedge clk or negedge reset_n) begin
    if (!reset_n) begin
      smp_ff <= '0;
    end else begin
      smp_ff <= nxt_smp;
    end
  end

  // ****************************************
  // Power control
  // ****************************************
  spd_state_t st_ff;
  spd_state_t nxt_st;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             pd_ff;
  logic             nxt_pd;

  always_comb begin
    nxt_st  = st_ff;
    nxt_cnt = cnt_ff;
    case (st_ff)
      SPD_RUN: begin
        if (low_power_request) begin
          nxt_st = SPD_SLEEP;
        end
      end
      SPD_SLEEP: begin
        if (!low_power_request) begin
          nxt_st  = SPD_SETTLE;
          nxt_cnt = SETTLE_LOAD;
        end
      end
      SPD_SETTLE: begin
        if (low_power_request) begin
          nxt_st = SPD_SLEEP;
        end else if (cnt_ff == CNT_W'(1)) begin
          nxt_st  = SPD_RUN;
          nxt_cnt = CNT_ZERO;
        end else begin
          nxt_cnt = cnt_ff - CNT_W'(1);
        end
      end
      default: begin
        nxt_st  = SPD_RUN;
        nxt_cnt = CNT_ZERO;
      end
    endcase
    // Status output from its own flop, not a decode
    nxt_pd = (nxt_st == SPD_SLEEP);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff  <= SPD_RUN;
      cnt_ff <= CNT_ZERO;
      pd_ff  <= 1'b0;
    end else begin
      st_ff  <= nxt_st;
      cnt_ff <= nxt_cnt;
      pd_ff  <= nxt_pd;
    end
  end

  assign powered_down = pd_ff;

  // ****************************************
  // Pipeline stages
  // ****************************************
  logic       buf_in_ready;
  logic       adv;
  logic       push;
  logic [7:0] code1_ff;
  logic [7:0] nxt_code1;
  logic [7:0] code2_ff;
  logic [7:0] nxt_code2;
  logic       v1_ff;
  logic       nxt_v1;
  logic       v2_ff;
  logic       nxt_v2;

  // run only while request is low
  // Back-pressure from the buffer stalls the pipe, so no word is lost
  assign adv  = !low_power_request && buf_in_ready;
  assign push = adv && v2_ff;

  always_comb begin
    nxt_code1 = code1_ff;
    nxt_code2 = code2_ff;
    nxt_v1    = v1_ff;
    nxt_v2    = v2_ff;
    if (adv) begin
      nxt_code1 = quantise(smp_ff, ref_bottom_level, ref_top_level);
      nxt_code2 = code1_ff;
      nxt_v1    = 1'b1;
      nxt_v2    = v1_ff;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      code1_ff <= CODE_ZERO;
      code2_ff <= CODE_ZERO;
      v1_ff    <= 1'b0;
      v2_ff    <= 1'b0;
    end else begin
      code1_ff <= nxt_code1;
      code2_ff <= nxt_code2;
      v1_ff    <= nxt_v1;
      v2_ff    <= nxt_v2;
    end
  end

  // ****************************************
  // Output buffer
  // ****************************************
  logic       word_settled;
  logic [8:0] out_word;

  assign word_settled = (st_ff == SPD_RUN);

  // third rising edge lands in the output register
  // outputs are flops, so a stopped clock holds them
  spd_skid_buf #(
    .W (9)
  ) u_buf (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (push),
    .in_ready  (buf_in_ready),
    .in_data   ({word_settled, code2_ff}),
    .out_valid (code_valid),
    .out_ready (code_ready),
    .out_data  (out_word)
  );

  assign code_out     = out_word[7:0];
  assign code_settled = out_word[8];

  // ****************************************
  // Checks
  // ****************************************
  sequence s_two_adv;
    adv ##1 adv;
  endsequence

  sequence s_release;
    $fell(low_power_request);
  endsequence

  a_code_zero: assert property (@(posedge clk) disable iff (!reset_n)
    (adv && smp_ff <= ref_bottom_level) |=> (code1_ff == CODE_ZERO))
    else $error("below-span sample did not give zero code");

  a_code_ones: assert property (@(posedge clk) disable iff (!reset_n)
    (adv && smp_ff >= ref_top_level && smp_ff > ref_bottom_level)
      |=> (code1_ff == CODE_ONES))
    else $error("above-span sample did not give all-ones code");

  a_code_order: assert property (@(posedge clk) disable iff (!reset_n)
    (adv && smp_ff > ref_bottom_level && smp_ff < ref_top_level)
      |=> (code1_ff != CODE_ONES || ref_top_level - ref_bottom_level == IN_W'(1)))
    else $error("in-span sample saturated");

  a_pipe_latency: assert property (@(posedge clk) disable iff (!reset_n)
    s_two_adv |=> (code2_ff == $past(code1_ff, 1)))
    else $error("stage two did not carry stage one code");

  a_run_fill: assert property (@(posedge clk) disable iff (!reset_n)
    adv |=> v1_ff)
    else $error("running pipeline lost its valid");

  a_pd_hold: assert property (@(posedge clk) disable iff (!reset_n)
    low_power_request |-> !push ##1 ($stable(code2_ff) && $stable(code1_ff)))
    else $error("pipeline moved while powered down");

  a_settle_load: assert property (@(posedge clk) disable iff (!reset_n)
    (s_release and (st_ff == SPD_SLEEP)) |=> (cnt_ff == SETTLE_LOAD && !word_settled))
    else $error("blanking count not loaded on release");

  a_settle_tag: assert property (@(posedge clk) disable iff (!reset_n)
    (st_ff == SPD_SETTLE && cnt_ff != CNT_W'(1) && !low_power_request)
      |=> (st_ff == SPD_SETTLE && !word_settled))
    else $error("blanking ended early");

  a_word_rate: assert property (@(posedge clk) disable iff (!reset_n)
    push |=> code_valid)
    else $error("pipeline word not delivered");

  a_pd_enter: assert property (@(posedge clk) disable iff (!reset_n)
    low_power_request |=> powered_down)
    else $error("request high did not power down");

  a_pd_leave: assert property (@(posedge clk) disable iff (!reset_n)
    !low_power_request |=> !powered_down)
    else $error("request low did not restore normal operation");

  a_pd_out_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (low_power_request && !code_valid) |=> (!code_valid && $stable(code_out)))
    else $error("output code moved while powered down");

  a_out_stall: assert property (@(posedge clk) disable iff (!reset_n)
    (code_valid && !code_ready)
      |=> (code_valid && $stable(code_out) && $stable(code_settled)))
    else $error("offered word changed before it was taken");

  a_push_lands: assert property (@(posedge clk) disable iff (!reset_n)
    (push && (code_ready || !code_valid))
      |=> (code_valid && code_out == $past(code2_ff)))
    else $error("pushed code did not reach the outputs");

  a_tag_travel: assert property (@(posedge clk) disable iff (!reset_n)
    (push && (code_ready || !code_valid))
      |=> (code_settled == $past(word_settled)))
    else $error("settled tag did not travel with its word");

  a_stage_fill: assert property (@(posedge clk) disable iff (!reset_n)
    (adv && v1_ff) |=> v2_ff)
    else $error("second stage did not fill");

  a_settle_exit: assert property (@(posedge clk) disable iff (!reset_n)
    (st_ff == SPD_SETTLE && cnt_ff == CNT_W'(1) && !low_power_request)
      |=> (st_ff == SPD_RUN && word_settled))
    else $error("blanking did not end on time");

  a_settle_count: assert property (@(posedge clk) disable iff (!reset_n)
    (st_ff == SPD_SETTLE) |-> (cnt_ff != CNT_ZERO && cnt_ff <= SETTLE_LOAD))
    else $error("blanking count out of range");

endmodule

// ===== design/spd_pkg.sv
// Shared constants and types for the sampling pipeline with power-down
package spd_pkg;

  // ****************************************
  // Code format
  // ****************************************
  localparam int          CODE_W    = 8;
  localparam logic [7:0]  CODE_ZERO = 8'h00;
  localparam logic [7:0]  CODE_ONES = 8'hff;
  localparam int          IN_W_DEF  = 12;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLK_MHZ        = 50;
  localparam int          SETTLE_TIME_US = 1;
  localparam int          SETTLE_CYC     = SETTLE_TIME_US * CLK_MHZ;
  localparam int          CNT_W          = 6;
  localparam logic [5:0]  SETTLE_LOAD    = 6'(SETTLE_CYC);
  localparam logic [5:0]  CNT_ZERO       = 6'h00;

  // ****************************************
  // Power states
  // ****************************************
  typedef enum logic [2:0] {
    SPD_RUN    = 3'h1,
    SPD_SLEEP  = 3'h2,
    SPD_SETTLE = 3'h4
  } spd_state_t;

endpackage

// ===== design/spd_skid_buf.sv
// Two-entry skid buffer between the converter pipeline and the capturing logic
`timescale 1ns/1ps
module spd_skid_buf #(
  parameter int W = 9
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         in_valid,
  output      logic         in_ready,
  input  wire logic [W-1:0] in_data,
  output      logic         out_valid,
  input  wire logic         out_ready,
  output      logic [W-1:0] out_data
);

  // ****************************************
  // Storage
  // ****************************************
  logic         out_v_ff;
  logic         nxt_out_v;
  logic [W-1:0] out_d_ff;
  logic [W-1:0] nxt_out_d;
  logic         sk_v_ff;
  logic         nxt_sk_v;
  logic [W-1:0] sk_d_ff;
  logic [W-1:0] nxt_sk_d;

  // Ready depends only on the skid slot, so it never loops back from out_ready
  assign in_ready  = !sk_v_ff;
  assign out_valid = out_v_ff;
  assign out_data  = out_d_ff;

  always_comb begin
    nxt_out_v = out_v_ff;
    nxt_out_d = out_d_ff;
    nxt_sk_v  = sk_v_ff;
    nxt_sk_d  = sk_d_ff;
    if (out_v_ff && out_ready) begin
      if (sk_v_ff) begin
        nxt_out_d = sk_d_ff;
        nxt_sk_v  = 1'b0;
      end else begin
        nxt_out_v = 1'b0;
      end
    end
    if (in_valid && !sk_v_ff) begin
      if (!nxt_out_v) begin
        nxt_out_v = 1'b1;
        nxt_out_d = in_data;
      end else begin
        nxt_sk_v = 1'b1;
        nxt_sk_d = in_data;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_v_ff <= 1'b0;
      out_d_ff <= '0;
      sk_v_ff  <= 1'b0;
      sk_d_ff  <= '0;
    end else begin
      out_v_ff <= nxt_out_v;
      out_d_ff <= nxt_out_d;
      sk_v_ff  <= nxt_sk_v;
      sk_d_ff  <= nxt_sk_d;
    end
  end

  // Stalled word stays put
  a_stall_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (out_v_ff && !out_ready) |=> (out_v_ff && $stable(out_d_ff)))
    else $error("buffer output changed while stalled");

endmodule

// ===== verification/spd_capture_model.sv
// Capturing-side model that accepts words and keeps only settled ones
`timescale 1ns/1ps
module spd_capture_model
  import spd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] code_out,
  input  wire logic       code_valid,
  input  wire logic       code_settled,
  input  wire logic       stall,
  output      logic       code_ready
);
  // ****************************************
  // Capture side
  // ****************************************
  logic [7:0] got_q[$];
  int         drop_cnt_ff;
  int         take_cnt_ff;

  // Stall drops ready to push back on the buffer
  assign code_ready = !stall;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      drop_cnt_ff <= 0;
      take_cnt_ff <= 0;
    end else if (code_valid && code_ready) begin
      take_cnt_ff <= take_cnt_ff + 1;
      if (code_settled) begin
        got_q.push_back(code_out);
      end else begin
        drop_cnt_ff <= drop_cnt_ff + 1;
      end
    end
  end
endmodule

// ===== verification/spd_converter_tb.sv
// Self-checking testbench for the sampling pipeline with power-down
`timescale 1ns/1ps
module sample_pipeline_power_down_tb_top
  import spd_pkg::*;
;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic        clk;
  logic        reset_n;
  logic [11:0] sample_in;
  logic [11:0] ref_bottom_level;
  logic [11:0] ref_top_level;
  logic        low_power_request;
  logic        stall;
  logic [7:0]  code_out;
  logic        code_valid;
  logic        code_settled;
  logic        code_ready;
  logic        powered_down;
  int          err_total;
  int          checked;

  spd_converter #(.IN_W(12)) dut_u (
    .clk(clk), .reset_n(reset_n), .sample_in(sample_in),
    .ref_bottom_level(ref_bottom_level), .ref_top_level(ref_top_level),
    .low_power_request(low_power_request), .code_out(code_out),
    .code_valid(code_valid), .code_settled(code_settled),
    .code_ready(code_ready), .powered_down(powered_down)
  );

  spd_capture_model cap_u (
    .clk(clk), .reset_n(reset_n), .code_out(code_out), .code_valid(code_valid),
    .code_settled(code_settled), .stall(stall), .code_ready(code_ready)
  );

  initial clk = 1'b0;
  always #10 clk = ~clk;

  // ****************************************
  // Helpers
  // ****************************************
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cmp1(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic report_and_stop();
    if (err_total == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Span 0x100..0x1ff gives code = input - bottom inside the span
  task automatic t_codes();
    logic [11:0] vin [6];
    logic [7:0]  vexp [6];
    int          i0;
    vin  = '{12'h000, 12'h100, 12'h101, 12'h1fe, 12'h1ff, 12'hfff};
    vexp = '{8'h00, 8'h00, 8'h01, 8'hfe, 8'hff, 8'hff};
    cap_u.got_q.delete();
    for (int i = 0; i < 6; i++) begin
      sample_in <= vin[i];
      @(negedge clk);
    end
    sample_in <= 12'h155;
    hold(10);
    i0 = 0;
    while (i0 < cap_u.got_q.size() && cap_u.got_q[i0] === 8'h55) i0++;
    for (int i = 0; i < 6; i++) cmp8(cap_u.got_q[i0 + i], vexp[i]);
  endtask

  // Value set here is taken at the next falling edge
  task automatic t_latency();
    sample_in <= 12'h1a0;
    hold(3);
    cmp8(code_out, 8'h55);
    hold(1);
    cmp8(code_out, 8'ha0);
  endtask

  task automatic t_power();
    logic [7:0] last;
    int         n;
    low_power_request <= 1'b1;
    hold(3);
    cmp1(powered_down, 1'b1);
    last = code_out;
    n = cap_u.take_cnt_ff;
    sample_in <= 12'h1ff;
    hold(8);
    cmp8(code_out, last);
    cmp1(cap_u.take_cnt_ff == n, 1'b1);
    low_power_request <= 1'b0;
    n = cap_u.drop_cnt_ff;
    hold(2);
    cmp1(powered_down, 1'b0);
    // Request again mid-blanking; release must restart the full blanking
    low_power_request <= 1'b1;
    hold(2);
    cmp1(powered_down, 1'b1);
    low_power_request <= 1'b0;
    hold(2);
    cmp1(powered_down, 1'b0);
    hold(SETTLE_CYC - 1);
    cmp1(code_settled, 1'b0);
    hold(1);
    cmp1(code_settled, 1'b1);
    cmp1(cap_u.drop_cnt_ff > n, 1'b1);
    cmp8(code_out, 8'hff);
  endtask

  // Stall fills the buffer; order must survive the back-pressure
  task automatic t_stall();
    logic [7:0] held;
    logic       ok;
    sample_in <= 12'h110;
    hold(6);
    cap_u.got_q.delete();
    for (int i = 0; i < 40; i++) begin
      sample_in <= 12'h110 + 12'(i);
      stall <= (i >= 10 && i < 20);
      if (i == 12) held = code_out;
      if (i == 19) begin
        cmp1(code_valid, 1'b1);
        cmp8(code_out, held);
      end
      @(negedge clk);
    end
    stall <= 1'b0;
    hold(10);
    ok = (cap_u.got_q.size() > 20);
    for (int i = 1; i < cap_u.got_q.size(); i++) begin
      if (!(cap_u.got_q[i] >= cap_u.got_q[i - 1])) ok = 1'b0;
    end
    cmp1(ok, 1'b1);
    cmp8(cap_u.got_q[$], 8'h37);
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    err_total = 0;
    checked = 0;
    reset_n = 1'b0;
    sample_in = 12'h155;
    ref_bottom_level = 12'h100;
    ref_top_level = 12'h1ff;
    low_power_request = 1'b0;
    stall = 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    reset_n <= 1'b1;
    hold(10);
    t_codes();
    t_latency();
    t_power();
    t_stall();
    report_and_stop();
  end

  // Whole run is under 200 cycles; this is far beyond it
  initial begin
    #100000;
    err_total++;
    report_and_stop();
  end
endmodule
